// ---- rtl/des_pkg.sv ----
// Shared constants and types of the data-enable stamping block
package des_pkg;

    // ****************************************************
    // Register offsets
    // ****************************************************
    localparam logic [7:0] DES_OFS_MODE_CTRL = 8'h00;
    localparam logic [7:0] DES_OFS_STAMP_CTRL = 8'h01;
    localparam logic [7:0] DES_OFS_IRQ_A_ROUTE = 8'h02;
    localparam logic [7:0] DES_OFS_PIN_CTRL = 8'h03;
    localparam logic [7:0] DES_OFS_STATUS = 8'h04;

    // ****************************************************
    // Field positions
    // ****************************************************
    // gate_mode_control
    localparam int DES_BIT_TRIGGER_SELECT = 7;
    localparam int DES_BIT_LEVEL_SELECT_A = 6;
    localparam int DES_BIT_LEVEL_SELECT_B = 5;
    // gate_stamp_control
    localparam int DES_BIT_STAMP_AXIS_X = 7;
    localparam int DES_BIT_STAMP_AXIS_Y = 6;
    localparam int DES_BIT_STAMP_AXIS_Z = 5;
    localparam int DES_BIT_STAMP_SENSOR_SELECT = 4;
    localparam int DES_BIT_GATE_EXTEND_ACCEL = 3;
    localparam int DES_BIT_GATE_POLARITY = 2;
    // irq_a_routing
    localparam int DES_BIT_GATE_READY_ROUTE = 7;
    // pin_behaviour_control
    localparam int DES_BIT_IRQ_POLARITY = 5;
    localparam int DES_BIT_IRQ_DRIVE_STYLE = 4;
    // status (read only)
    localparam int DES_BIT_ST_LATCHED = 0;
    localparam int DES_BIT_ST_FIFO_GATING = 1;
    localparam int DES_BIT_ST_GATE_ACTIVE = 2;
    localparam int DES_BIT_ST_WINDOW_PHASE = 3;
    localparam int DES_BIT_ST_PULSE_PENDING = 4;
    localparam int DES_BIT_ST_IRQ_A_LEVEL = 5;
    localparam int DES_BIT_ST_IRQ_B_LEVEL = 6;

    // ****************************************************
    // Reset values
    // ****************************************************
    localparam logic [7:0] DES_RST_MODE_CTRL = 8'h00;
    localparam logic [7:0] DES_RST_STAMP_CTRL = 8'he0;
    localparam logic [7:0] DES_RST_IRQ_A_ROUTE = 8'h00;
    localparam logic [7:0] DES_RST_PIN_CTRL = 8'h00;
    localparam logic DES_RST_WINDOW_PHASE = 1'b1;

    // ****************************************************
    // Types
    // ****************************************************
    // Gate mode, coded as {trigger_select, level_select_a, level_select_b}
    typedef enum logic [2:0] {
        DES_MODE_OFF = 3'b000,
        DES_MODE_EDGE = 3'b100,
        DES_MODE_LEVEL = 3'b010,
        DES_MODE_LATCHED = 3'b011,
        DES_MODE_FIFO_GATING = 3'b110
    } des_mode_type;

    // One three-axis sample
    typedef struct packed {
        logic [15:0] x;
        logic [15:0] y;
        logic [15:0] z;
    } des_axes_type;

    // Axis selection for stamping
    typedef struct packed {
        logic x;
        logic y;
        logic z;
    } des_axis_sel_type;

endpackage

// ---- rtl/des_stamp.sv ----
// Data-enable stamping and FIFO gating on the motion sample path
//
// Behaviour
// [R01] Latched stamping mode when both level selects are 1 and trigger select 0.
// [R02] Latched mode: stamp LSB 0, and 1 only on first sample after a pulse.
// [R03] Gate level taken once just before each update; later changes wait.
// [R04] Host keeps accel and gyro at equal rate, or gyro off, when extended.
// [R05] Latched mode with ready routing: pulse pin A on first stamped sample.
// [R06] FIFO-gating mode when trigger select and level select A are 1, B 0.
// [R07] FIFO-gating mode: FIFO writes only while sampled gate is active.
// [R08] FIFO-gating mode: stamp 0 on odd windows, 1 on even, toggling.
// [R09] Host sets gyro batch rate equal to gyro output rate in gating mode.
// [R10] Host sets accel batch rate equal to accel output rate when extended.
// [R11] Host keeps configuration-change FIFO entries disabled in gating mode.
// [R12] Host sets timestamp batch decimation field to 00 in gating mode.
// [R13] Stamp only selected axes, of gyro (select 0) or accel (select 1).
// [R14] After reset stamping targets all three gyro axes.
// [R15] Polarity 0: pins idle low, high on event; 1: idle high, low on event.
// [R16] Drive style 0: both levels driven; 1: only active level driven.
// [R17] Any gate mode makes pin B an input carrying the gate signal.
// [R18] Gate input active low by default, active high with polarity bit set.
// [R19] Gate acts on gyro only unless the accel extension bit is 1.
// [R20] Gate input synchronised; pulse is inactive-to-active between samples.
//
// The address-and-strobe port and the address map were left to the implementer.
`timescale 1ns/1ns
module des_stamp
    import des_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    // Register port
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    // Sample path in
    input wire logic i_g_update,
    input wire des_axes_type i_g_data,
    input wire logic i_xl_update,
    input wire des_axes_type i_xl_data,
    // Sample path out
    output logic o_g_valid,
    output des_axes_type o_g_data,
    output logic o_g_fifo_wr,
    output logic o_xl_valid,
    output des_axes_type o_xl_data,
    output logic o_xl_fifo_wr,
    // Interrupt pin A
    input wire logic i_irq_pin_a_in,
    output logic o_irq_pin_a_out,
    output logic o_irq_pin_a_oe_n,
    // Interrupt pin B, also the sample_gate_input
    input wire logic i_irq_b_event,
    input wire logic i_irq_pin_b_in,
    output logic o_irq_pin_b_out,
    output logic o_irq_pin_b_oe_n
);

    // ****************************************************
    // Functions
    // ****************************************************
    // Decode mode bits; unlisted codes act as gate off
    function automatic des_mode_type des_decode_mode(input logic [7:0] ctrl);
        logic [2:0] code;
        code = {ctrl[DES_BIT_TRIGGER_SELECT], ctrl[DES_BIT_LEVEL_SELECT_A],
                ctrl[DES_BIT_LEVEL_SELECT_B]};
        unique case (code)
            3'b000: des_decode_mode = DES_MODE_OFF;
            3'b100: des_decode_mode = DES_MODE_EDGE;
            3'b010: des_decode_mode = DES_MODE_LEVEL;
            3'b011: des_decode_mode = DES_MODE_LATCHED; // see [R01]
            3'b110: des_decode_mode = DES_MODE_FIFO_GATING; // see [R06]
            default: des_decode_mode = DES_MODE_OFF;
        endcase
    endfunction

    // Replace LSB of the selected axes with the stamp bit
    function automatic des_axes_type des_apply_stamp(
        input des_axes_type data,
        input des_axis_sel_type sel,
        input logic en,
        input logic stamp
    );
        des_axes_type res;
        res = data;
        if (en && sel.x)
            res.x[0] = stamp; // see [R13]
        if (en && sel.y)
            res.y[0] = stamp;
        if (en && sel.z)
            res.z[0] = stamp;
        des_apply_stamp = res;
    endfunction

    // Pin level and enable from event, polarity and drive style
    function automatic logic [1:0] des_pin_drive(
        input logic event_on,
        input logic pol,
        input logic style
    );
        logic lvl;
        logic oe_n;
        lvl = event_on ^ pol; // see [R15]
        oe_n = style & ~event_on; // see [R16]
        des_pin_drive = {lvl, oe_n};
    endfunction

    // ****************************************************
    // Registers
    // ****************************************************
    logic [7:0] mode_ctrl_q;
    logic [7:0] stamp_ctrl_q;
    logic [7:0] irq_a_route_q;
    logic [7:0] pin_ctrl_q;
    logic [7:0] rdata_q;
    logic gate_sync1_q;
    logic gate_sync2_q;
    logic gate_prev_q;
    logic pulse_pend_q;
    logic pulse_pend_d;
    logic window_prev_q;
    logic window_phase_q;
    logic window_phase_d;
    logic g_valid_q;
    logic xl_valid_q;
    logic g_fifo_wr_q;
    logic xl_fifo_wr_q;
    des_axes_type g_data_q;
    des_axes_type xl_data_q;
    logic ready_pulse_q;
    logic irq_a_out_q;
    logic irq_a_oe_n_q;
    logic irq_b_out_q;
    logic irq_b_oe_n_q;

    // ****************************************************
    // Decoded controls
    // ****************************************************
    des_mode_type mode;
    logic gate_mode_on;
    logic is_latched;
    logic is_fifo_gating;
    logic extend_accel;
    logic sensor_is_accel;
    des_axis_sel_type axis_sel;
    logic gate_active;
    logic gate_pulse;
    logic any_update;
    logic latched_stamp;
    logic new_window;
    logic g_stamp_en;
    logic xl_stamp_en;
    logic [1:0] pin_a_drv;
    logic [1:0] pin_b_drv;

    assign mode = des_decode_mode(mode_ctrl_q);
    assign gate_mode_on = (mode != DES_MODE_OFF);
    assign is_latched = (mode == DES_MODE_LATCHED);
    assign is_fifo_gating = (mode == DES_MODE_FIFO_GATING);
    assign extend_accel = stamp_ctrl_q[DES_BIT_GATE_EXTEND_ACCEL];
    assign sensor_is_accel = stamp_ctrl_q[DES_BIT_STAMP_SENSOR_SELECT];
    assign axis_sel = '{x: stamp_ctrl_q[DES_BIT_STAMP_AXIS_X],
                        y: stamp_ctrl_q[DES_BIT_STAMP_AXIS_Y],
                        z: stamp_ctrl_q[DES_BIT_STAMP_AXIS_Z]};

    // Active level after polarity; default active low
    assign gate_active = stamp_ctrl_q[DES_BIT_GATE_POLARITY] ? gate_sync2_q
                                                               : ~gate_sync2_q; // see [R18]
    // Inactive-to-active between two synchronised samples
    assign gate_pulse = gate_active & ~gate_prev_q; // see [R20]

    // Gyro and accel share one rate when extended, so either update samples the gate
    assign any_update = i_g_update | i_xl_update; // see [R04]

    // A pulse in the update cycle itself is already seen by that update
    assign latched_stamp = pulse_pend_q | (gate_pulse & gate_mode_on); // see [R02]

    // A window opens on the first update that sees the gate active
    assign new_window = any_update & gate_active & ~window_prev_q; // see [R03]

    // Stamp gyro unless accel picked; accel only with extension
    assign g_stamp_en = (is_latched | is_fifo_gating) & ~sensor_is_accel; // see [R13]
    assign xl_stamp_en = (is_latched | is_fifo_gating) & sensor_is_accel
                         & extend_accel; // see [R19]

    // Pin drive decode for both interrupt pins
    assign pin_a_drv = des_pin_drive(ready_pulse_q, pin_ctrl_q[DES_BIT_IRQ_POLARITY],
                                     pin_ctrl_q[DES_BIT_IRQ_DRIVE_STYLE]);
    assign pin_b_drv = des_pin_drive(i_irq_b_event, pin_ctrl_q[DES_BIT_IRQ_POLARITY],
                                     pin_ctrl_q[DES_BIT_IRQ_DRIVE_STYLE]);

    // ****************************************************
    // Register writes
    // ****************************************************
    // Control registers; stamp control resets to all gyro axes
    always_ff @(posedge i_ref_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            mode_ctrl_q <= DES_RST_MODE_CTRL;
            stamp_ctrl_q <= DES_RST_STAMP_CTRL; // see [R14]
            irq_a_route_q <= DES_RST_IRQ_A_ROUTE;
            pin_ctrl_q <= DES_RST_PIN_CTRL;
        end
        else if (i_wr)
        begin
            unique case (i_addr)
                DES_OFS_MODE_CTRL: mode_ctrl_q <= i_wdata;
                DES_OFS_STAMP_CTRL: stamp_ctrl_q <= i_wdata;
                DES_OFS_IRQ_A_ROUTE: irq_a_route_q <= i_wdata;
                DES_OFS_PIN_CTRL: pin_ctrl_q <= i_wdata;
                default: ; // Status is read only; unmapped writes dropped
            endcase
        end
    end

    // ****************************************************
    // Register reads
    // ****************************************************
    // Read data valid for exactly one cycle; zero otherwise
    always_ff @(posedge i_ref_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            rdata_q <= 8'h00;
        else if (i_rd)
        begin
            unique case (i_addr)
                DES_OFS_MODE_CTRL: rdata_q <= mode_ctrl_q;
                DES_OFS_STAMP_CTRL: rdata_q <= stamp_ctrl_q;
                DES_OFS_IRQ_A_ROUTE: rdata_q <= irq_a_route_q;
                DES_OFS_PIN_CTRL: rdata_q <= pin_ctrl_q;
                DES_OFS_STATUS:
                begin
                    rdata_q <= 8'h00;
                    rdata_q[DES_BIT_ST_LATCHED] <= is_latched;
                    rdata_q[DES_BIT_ST_FIFO_GATING] <= is_fifo_gating;
                    rdata_q[DES_BIT_ST_GATE_ACTIVE] <= window_prev_q;
                    rdata_q[DES_BIT_ST_WINDOW_PHASE] <= window_phase_q;
                    rdata_q[DES_BIT_ST_PULSE_PENDING] <= pulse_pend_q;
                    rdata_q[DES_BIT_ST_IRQ_A_LEVEL] <= i_irq_pin_a_in;
                    rdata_q[DES_BIT_ST_IRQ_B_LEVEL] <= i_irq_pin_b_in;
                end
                default: rdata_q <= 8'h00;
            endcase
        end
        else
            rdata_q <= 8'h00;
    end

    // ****************************************************
    // Gate input synchroniser
    // ****************************************************
    // Two flops; only the second feeds logic, a third gives the prior sample
    always_ff @(posedge i_ref_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            gate_sync1_q <= 1'b0;
            gate_sync2_q <= 1'b0;
            gate_prev_q <= 1'b0;
        end
        else
        begin
            gate_sync1_q <= i_irq_pin_b_in; // see [R17]
            gate_sync2_q <= gate_sync1_q;
            gate_prev_q <= gate_active; // see [R20]
        end
    end

    // ****************************************************
    // Latched pulse capture
    // ****************************************************
    // Held until the next update; short pulses between updates are not lost
    always_comb
    begin
        pulse_pend_d = pulse_pend_q;
        if (!is_latched)
            pulse_pend_d = 1'b0;
        else if (any_update)
            pulse_pend_d = 1'b0; // see [R03]
        else if (gate_pulse)
            pulse_pend_d = 1'b1; // see [R02]
    end

    always_ff @(posedge i_ref_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            pulse_pend_q <= 1'b0;
        else
            pulse_pend_q <= pulse_pend_d;
    end

    // ****************************************************
    // FIFO gating windows
    // ****************************************************
    // Phase restarts on mode entry, so the first window is odd and stamps 0
    always_comb
    begin
        window_phase_d = window_phase_q;
        if (!is_fifo_gating)
            window_phase_d = DES_RST_WINDOW_PHASE;
        else if (new_window)
            window_phase_d = ~window_phase_q; // see [R08]
    end

    // Gate level as sampled at the last update
    always_ff @(posedge i_ref_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            window_prev_q <= 1'b0;
            window_phase_q <= DES_RST_WINDOW_PHASE;
        end
        else
        begin
            if (any_update)
            begin
                window_prev_q <= gate_active; // see [R03]
            end
            window_phase_q <= window_phase_d;
        end
    end

    // ****************************************************
    // Sample output stage
    // ****************************************************
    // Gyro path; FIFO write gated by the gate level taken at this update
    always_ff @(posedge i_ref_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            g_valid_q <= 1'b0;
            g_fifo_wr_q <= 1'b0;
            g_data_q <= '0;
        end
        else
        begin
            g_valid_q <= i_g_update;
            g_fifo_wr_q <= i_g_update & (~is_fifo_gating | gate_active); // see [R07]
            if (i_g_update)
            begin
                g_data_q <= des_apply_stamp(i_g_data, axis_sel, g_stamp_en,
                                            is_latched ? latched_stamp
                                                       : window_phase_d);
            end
        end
    end

    // Accel path; gating only when the extension bit is set
    always_ff @(posedge i_ref_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            xl_valid_q <= 1'b0;
            xl_fifo_wr_q <= 1'b0;
            xl_data_q <= '0;
        end
        else
        begin
            xl_valid_q <= i_xl_update;
            xl_fifo_wr_q <= i_xl_update
                            & (~(is_fifo_gating & extend_accel) | gate_active); // see [R19]
            if (i_xl_update)
            begin
                xl_data_q <= des_apply_stamp(i_xl_data, axis_sel, xl_stamp_en,
                                             is_latched ? latched_stamp
                                                        : window_phase_d);
            end
        end
    end

    // ****************************************************
    // Gate ready pulse
    // ****************************************************
    // One cycle, aligned with the output of the first stamped sample
    always_ff @(posedge i_ref_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            ready_pulse_q <= 1'b0;
        else
            ready_pulse_q <= is_latched & any_update & latched_stamp
                             & irq_a_route_q[DES_BIT_GATE_READY_ROUTE]; // see [R05]
    end

    // ****************************************************
    // Interrupt pins
    // ****************************************************
    // Registered one cycle after the pulse, so the pin trails data by a cycle
    always_ff @(posedge i_ref_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            irq_a_out_q <= 1'b0;
            irq_a_oe_n_q <= 1'b0;
            irq_b_out_q <= 1'b0;
            irq_b_oe_n_q <= 1'b0;
        end
        else
        begin
            irq_a_out_q <= pin_a_drv[1]; // see [R15]
            irq_a_oe_n_q <= pin_a_drv[0]; // see [R16]
            irq_b_out_q <= pin_b_drv[1];
            // Pin B turns to input in every gate mode
            irq_b_oe_n_q <= gate_mode_on | pin_b_drv[0]; // see [R17]
        end
    end

    // ****************************************************
    // Outputs
    // ****************************************************
    assign o_rdata = rdata_q;
    assign o_g_valid = g_valid_q;
    assign o_g_data = g_data_q;
    assign o_g_fifo_wr = g_fifo_wr_q;
    assign o_xl_valid = xl_valid_q;
    assign o_xl_data = xl_data_q;
    assign o_xl_fifo_wr = xl_fifo_wr_q;
    assign o_irq_pin_a_out = irq_a_out_q;
    assign o_irq_pin_a_oe_n = irq_a_oe_n_q;
    assign o_irq_pin_b_out = irq_b_out_q;
    assign o_irq_pin_b_oe_n = irq_b_oe_n_q;

endmodule

// ---- bench/des_gate_src.sv ----
// Model of the external trigger driving the sample gate pin
`timescale 1ns/1ns
module des_gate_src
(
    input wire logic i_ref_clk,
    output logic o_pin
);
    initial o_pin = 1'b1;
    // Level changes just after an edge, then holds
    task automatic drive(input logic lvl, input int hold);
        @(posedge i_ref_clk);
        o_pin <= lvl;
        repeat (hold) @(posedge i_ref_clk);
    endtask
endmodule

// ---- bench/des_stamp_monitor.sv ----
// Port-level checker of the stamping block
`timescale 1ns/1ns
module des_stamp_monitor
    import des_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_g_update,
    input wire des_axes_type i_g_data,
    input wire logic i_xl_update,
    input wire des_axes_type i_xl_data,
    input wire logic o_g_valid,
    input wire des_axes_type o_g_data,
    input wire logic o_g_fifo_wr,
    input wire logic o_xl_valid,
    input wire des_axes_type o_xl_data,
    input wire logic o_xl_fifo_wr,
    input wire logic i_irq_pin_b_in,
    input wire logic o_irq_pin_a_out,
    input wire logic o_irq_pin_a_oe_n,
    input wire logic o_irq_pin_b_oe_n
);
    // ****************************************************
    // Shadow of the control registers
    // ****************************************************
    logic [2:0] mode_q;
    logic [7:0] sctl_q;
    logic [1:0] pctl_q;
    logic route_q;
    logic [1:0] quiet_q;
    logic q;
    // Rules are scoped by the mode the host last wrote
    always_ff @(posedge i_ref_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            mode_q <= DES_RST_MODE_CTRL[7:5];
            sctl_q <= DES_RST_STAMP_CTRL;
            pctl_q <= DES_RST_PIN_CTRL[5:4];
            route_q <= DES_RST_IRQ_A_ROUTE[7];
        end
        else if (i_wr)
        begin
            if (i_addr == DES_OFS_MODE_CTRL) mode_q <= i_wdata[7:5];
            if (i_addr == DES_OFS_STAMP_CTRL) sctl_q <= i_wdata;
            if (i_addr == DES_OFS_PIN_CTRL) pctl_q <= i_wdata[5:4];
            if (i_addr == DES_OFS_IRQ_A_ROUTE) route_q <= i_wdata[7];
        end
    end
    // Pin outputs lag a write by a cycle
    always_ff @(posedge i_ref_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            quiet_q <= 2'h0;
        else if (i_wr)
            quiet_q <= 2'h0;
        else if (quiet_q != 2'h3)
            quiet_q <= quiet_q + 2'h1;
    end
    assign q = quiet_q == 2'h3;

    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_nrst);
    property p_valid;
        i_g_update |=> o_g_valid && o_g_data.y[15:1] == $past(i_g_data.y[15:1]);
    endproperty
    a_valid: assert property (p_valid) else $error("gyro sample lost");
    property p_pin_b;
        q && mode_q != 3'h0 |-> o_irq_pin_b_oe_n;
    endproperty
    a_pin_b: assert property (p_pin_b) else $error("pin B still driven");
    property p_drive;
        q && pctl_q[0] && !o_irq_pin_a_oe_n |-> o_irq_pin_a_out == !pctl_q[1];
    endproperty
    a_drive: assert property (p_drive) else $error("open drain drives idle");
    property p_ready;
        q && route_q && mode_q == DES_MODE_LATCHED && pctl_q == 2'h0 && o_g_valid
            && sctl_q[7] && !sctl_q[4] && o_g_data.x[0] |=> o_irq_pin_a_out;
    endproperty
    a_ready: assert property (p_ready) else $error("no ready pulse");
    property p_idle;
        q && pctl_q == 2'h0 && o_irq_pin_a_out |-> $past(o_g_valid || o_xl_valid);
    endproperty
    a_idle: assert property (p_idle) else $error("pin A active unprompted");
    property p_gate;
        q && mode_q == DES_MODE_FIFO_GATING && i_g_update && $stable(i_irq_pin_b_in)
            && $past(i_irq_pin_b_in, 2) == i_irq_pin_b_in
            && $past(i_irq_pin_b_in, 3) == i_irq_pin_b_in
            |=> o_g_fifo_wr == ($past(i_irq_pin_b_in) == sctl_q[2]);
    endproperty
    a_gate: assert property (p_gate) else $error("FIFO write ignores gate");
    property p_unsel;
        q && mode_q != 3'h0 && i_g_update && !sctl_q[5] |=> o_g_data.z[0] == $past(i_g_data.z[0]);
    endproperty
    a_unsel: assert property (p_unsel) else $error("unselected axis stamped");
    property p_xl;
        q && !sctl_q[3] && i_xl_update |=> o_xl_data == $past(i_xl_data) && o_xl_fifo_wr;
    endproperty
    a_xl: assert property (p_xl) else $error("accel touched");
    c_ready: cover property (o_irq_pin_a_out);
    c_gated: cover property (o_g_valid && !o_g_fifo_wr);
    c_win: cover property (o_g_fifo_wr && o_g_data.x[0]);
endmodule

bind des_stamp des_stamp_monitor des_stamp_monitor_inst (.*);

// ---- bench/data_enable_stamping_tb_top.sv ----
// Self-checking bench of the stamping block
`timescale 1ns/1ns
module data_enable_stamping_tb_top;
    import des_pkg::*;
    localparam des_axes_type D = 48'h1111_2223_3335;
    localparam logic [47:0] L = 48'h0001_0001_0001;
    logic clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0, gu = 1'b0, xu = 1'b0, ev = 1'b0;
    logic [7:0] addr = 8'h00, wd = 8'h00, rdata;
    logic gv, gf, xv, xf, a_out, a_oe_n, b_out, b_oe_n, src, pin_a, pin_b;
    des_axes_type gd, xd;
    int err_total = 0, cmp_count = 0;
    // Pull-up on pin A; pin B is the trigger's once the block lets go
    assign pin_a = a_oe_n ? 1'b1 : a_out;
    assign pin_b = b_oe_n ? src : b_out;
    des_stamp des_stamp_inst (.i_ref_clk(clk), .i_nrst(nrst), .i_addr(addr), .i_wdata(wd),
        .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_g_update(gu), .i_g_data(D), .i_xl_update(xu),
        .i_xl_data(D), .o_g_valid(gv), .o_g_data(gd), .o_g_fifo_wr(gf), .o_xl_valid(xv),
        .o_xl_data(xd), .o_xl_fifo_wr(xf), .i_irq_pin_a_in(pin_a), .o_irq_pin_a_out(a_out),
        .o_irq_pin_a_oe_n(a_oe_n), .i_irq_b_event(ev), .i_irq_pin_b_in(pin_b),
        .o_irq_pin_b_out(b_out), .o_irq_pin_b_oe_n(b_oe_n));
    des_gate_src des_gate_src_inst (.i_ref_clk(clk), .o_pin(src));
    initial
    begin
        forever #50 clk = ~clk;
    end
    // ****************************************************
    // Bus and compare helpers
    // ****************************************************
    task chk(input logic [63:0] got, input logic [63:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task wreg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wd <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task rreg(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        chk(rdata, exp);
    endtask
    // One update on both sensors at once
    task upd();
        @(posedge clk);
        gu <= 1'b1;
        xu <= 1'b1;
        @(posedge clk);
        gu <= 1'b0;
        xu <= 1'b0;
        @(negedge clk);
        chk(gv & xv, 1'b1);
    endtask
    task pulse();
        des_gate_src_inst.drive(1'b0, 3);
        des_gate_src_inst.drive(1'b1, 4);
    endtask
    // ****************************************************
    // Scenarios
    // ****************************************************
    task t_regs();
        rreg(DES_OFS_MODE_CTRL, 8'h00);
        rreg(DES_OFS_STAMP_CTRL, 8'he0);
        rreg(8'h20, 8'h00);
        wreg(DES_OFS_MODE_CTRL, 8'h80);
        rreg(DES_OFS_STATUS, 8'h48);
    endtask
    task t_latched();
        des_gate_src_inst.drive(1'b1, 4);
        wreg(DES_OFS_MODE_CTRL, 8'h60);
        wreg(DES_OFS_IRQ_A_ROUTE, 8'h80);
        upd();
        chk(gd, D & ~L);
        chk(b_oe_n, 1'b1);
        pulse();
        upd();
        chk(gd, D);
        @(negedge clk);
        chk(a_out, 1'b1);
        upd();
        chk(gd, D & ~L);
        wreg(DES_OFS_STAMP_CTRL, 8'hc0);
        wreg(DES_OFS_PIN_CTRL, 8'h30);
        upd();
        chk(gd, D & ~48'h0001_0001_0000);
        pulse();
        upd();
        @(negedge clk);
        chk({a_oe_n, a_out}, 2'b00);
        @(negedge clk);
        chk(a_oe_n, 1'b1);
    endtask
    task t_gating();
        wreg(DES_OFS_PIN_CTRL, 8'h00);
        wreg(DES_OFS_STAMP_CTRL, 8'he4);
        wreg(DES_OFS_MODE_CTRL, 8'hc0);
        des_gate_src_inst.drive(1'b0, 4);
        upd();
        chk({gf, xf, xd}, {2'b01, D});
        des_gate_src_inst.drive(1'b1, 4);
        upd();
        chk({gf, gd}, {1'b1, D & ~L});
        upd();
        chk({gf, gd}, {1'b1, D & ~L});
        des_gate_src_inst.drive(1'b0, 4);
        upd();
        chk(gf, 1'b0);
        des_gate_src_inst.drive(1'b1, 4);
        upd();
        chk({gf, gd}, {1'b1, D});
    endtask
    task t_pins();
        logic [1:0] c;
        wreg(DES_OFS_MODE_CTRL, 8'h00);
        for (int i = 0; i < 8; i++)
        begin
            c = i[2:1];
            wreg(DES_OFS_PIN_CTRL, {2'b00, c, 4'h0});
            @(posedge clk);
            ev <= i[0];
            repeat (2) @(posedge clk);
            @(negedge clk);
            chk(b_oe_n, c[0] & !i[0]);
            if (!b_oe_n) chk(b_out, i[0] ^ c[1]);
        end
    endtask
    task conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Watchdog cuts a hang short
    initial
    begin
        repeat (5000) @(posedge clk);
        err_total++;
        conclude();
    end
    initial
    begin
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        t_regs();
        t_latched();
        t_gating();
        t_pins();
        conclude();
    end
endmodule
